//--- rtl/sbwcc_top.sv
// standby sequencer, watchdog and clock control with wishbone registers
// assumes a classic wishbone master and irq_i from logic on clk_i
`timescale 1ns/1ps
`default_nettype none

module sbwcc_top
	import sbwcc_pkg::*;
#(
	parameter logic [STAB_WIDTH-1:0] MAIN_TICKS = MAIN_STAB_TICKS,
	parameter logic [STAB_WIDTH-1:0] SUB_TICKS = SUB_STAB_TICKS,
	parameter int WD_W = WD_WIDTH
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// pins
	input wire logic reset_n_i,
	input wire logic main_osc_input_i,
	input wire logic sub_osc_input_i,
	// core side
	input wire logic irq_i,
	output logic cpu_halt_o,
	output logic internal_reset_o,
	output logic [7:0] timer_mode_o,
	// clock and display control
	output logic main_osc_en_o,
	output logic sub_osc_en_o,
	output logic sys_clk_sub_o,
	output logic display_enable_o,
	output logic display_frame_clock_sel_o
);

	typedef struct packed {
		logic [1:0] rsync;
		logic [7:0] lcd;
		logic [7:0] cpu;
		logic [7:0] tmr;
		logic stp_dis;
		sbwcc_state_t st;
		logic main_en;
		logic sub_en;
		logic stab_go;
		logic irst;
		logic ack;
		logic [31:0] dat;
	} sbwcc_top_t;

	sbwcc_top_t s;
	sbwcc_top_t next_s;
	logic rst_now;
	logic commit;
	logic wr_wd;

	sbwcc_clk_if ch ();

	// ------------------------------------------------
	// helpers
	// ------------------------------------------------
	function automatic logic hit(input logic [9:0] adr, input logic [7:0] idx);
		hit = (adr[9:2] == idx);
	endfunction

	function automatic logic [31:0] zext(input logic [7:0] v);
		zext = {24'h000000, v};
	endfunction

	// ------------------------------------------------
	// sub blocks
	// ------------------------------------------------
	sbwcc_osc #(
		.MAIN_TICKS(MAIN_TICKS),
		.SUB_TICKS(SUB_TICKS)
	) u_osc (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.main_osc_input_i(main_osc_input_i),
		.sub_osc_input_i(sub_osc_input_i),
		.ch(ch.osc)
	);

	sbwcc_wdog #(
		.WIDTH(WD_W)
	) u_wdog (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ch(ch.wdg)
	);

	// ------------------------------------------------
	// bus decode
	// ------------------------------------------------
	// writes land at the edge where the master sees ack, not earlier
	assign commit = wb_cyc_i & wb_stb_i & s.ack & wb_we_i & wb_sel_i[0];
	assign wr_wd = commit & hit(wb_adr_i, IDX_WDOG_CTRL);
	// the pin counts only after two flops; an underflow counts like the pin
	assign rst_now = ~s.rsync[1] | ch.wd_uflow; // R18

	assign ch.wd_tick = s.cpu[CPU_SYSSEL_BIT] ? ch.sub_tick : ch.main_tick; // R10
	assign ch.wd_run = (s.st != SB_STOP); // R6 R8
	assign ch.wd_load = wr_wd | rst_now;
	assign ch.stab_go = s.stab_go;
	assign ch.stab_main = ~s.cpu[CPU_SYSSEL_BIT];

	// ------------------------------------------------
	// next state
	// ------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.rsync = {s.rsync[0], reset_n_i};
		next_s.stab_go = 1'b0;
		next_s.irst = 1'b0;
		next_s.ack = wb_cyc_i & wb_stb_i & ~s.ack;

		// read data is captured on the request edge and stands with ack
		if (wb_cyc_i && wb_stb_i && !s.ack) begin
			case (wb_adr_i[9:2])
				IDX_LCD_MODE: next_s.dat = zext(s.lcd);
				IDX_CPU_MODE: next_s.dat = zext(s.cpu);
				IDX_TMR_MODE: next_s.dat = zext(s.tmr);
				IDX_WDOG_CTRL: next_s.dat = zext({1'b0, s.stp_dis, 6'h00});
				IDX_STBY_STAT: next_s.dat = {16'h0000, ch.wd_hi, 2'h0, s.main_en, s.sub_en, s.stp_dis,
					1'b0, s.st};
				default: next_s.dat = 32'h00000000;
			endcase
		end

		// register writes
		if (commit) begin
			if (hit(wb_adr_i, IDX_LCD_MODE)) begin
				next_s.lcd = wb_dat_i[7:0];
			end
			if (hit(wb_adr_i, IDX_CPU_MODE)) begin
				next_s.cpu = wb_dat_i[7:0];
			end
			if (hit(wb_adr_i, IDX_TMR_MODE)) begin
				next_s.tmr = wb_dat_i[7:0];
			end
			if (wr_wd) begin
				// only a one may be written; no write brings stop back
				next_s.stp_dis = s.stp_dis | wb_dat_i[WD_STPDIS_BIT]; // R11
			end
		end

		// standby sequence
		case (s.st)
			SB_RUN: begin
				if (commit && hit(wb_adr_i, IDX_STBY_CMD)) begin
					if (wb_dat_i[CMD_STOP_BIT] && !s.stp_dis) begin // R11
						next_s.st = SB_STOP;
					end else if (wb_dat_i[CMD_WAIT_BIT]) begin
						next_s.st = SB_WAIT;
					end
				end
				next_s.main_en = ~next_s.cpu[CPU_MAINSTOP_BIT];
				next_s.sub_en = next_s.cpu[CPU_SUBEN_BIT];
			end
			SB_WAIT: begin
				if (irq_i) begin
					next_s.st = SB_RUN;
				end
			end
			SB_STOP: begin
				next_s.main_en = 1'b0;
				next_s.sub_en = 1'b0;
				if (irq_i) begin
					next_s.st = SB_STABLE;
					next_s.main_en = ~s.cpu[CPU_MAINSTOP_BIT]; // R12
					next_s.sub_en = s.cpu[CPU_SUBEN_BIT]; // R12
					next_s.tmr = s.tmr & TMR_KEEP_MASK; // R13
					next_s.stab_go = 1'b1; // R14
				end
			end
			SB_STABLE: begin
				// the sub clock may still be settling when this ends
				if (ch.stab_done) begin // R14
					next_s.st = SB_RUN;
				end
			end
			default: begin
				next_s.st = SB_RUN;
			end
		endcase

		// internal reset from pin or watchdog overrides registers, state and enables, but not stab_go
		if (rst_now) begin
			next_s.irst = 1'b1;
			next_s.lcd = LCD_MODE_RST; // R1
			next_s.cpu = CPU_MODE_RST;
			next_s.tmr = TMR_MODE_RST;
			next_s.stp_dis = 1'b0;
			next_s.st = SB_RUN;
			next_s.main_en = 1'b1; // R15
			next_s.sub_en = 1'b0; // R2 R15
		end
	end

	// ------------------------------------------------
	// state register
	// ------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
			s.rsync <= 2'b11;
			s.lcd <= LCD_MODE_RST; // R1
			s.cpu <= CPU_MODE_RST;
			s.tmr <= TMR_MODE_RST;
			s.st <= SB_RUN;
			s.main_en <= 1'b1;
			s.sub_en <= 1'b0; // R2
		end else begin
			s <= next_s;
		end
	end

	// ------------------------------------------------
	// outputs
	// ------------------------------------------------
	assign wb_dat_o = s.dat;
	assign wb_ack_o = s.ack;
	assign cpu_halt_o = (s.st != SB_RUN);
	assign internal_reset_o = s.irst;
	assign timer_mode_o = s.tmr;
	assign main_osc_en_o = s.main_en;
	assign sub_osc_en_o = s.sub_en;
	assign sys_clk_sub_o = s.cpu[CPU_SYSSEL_BIT];
	// the display is not forced off in stop, software must clear it first
	assign display_enable_o = s.lcd[LCD_EN_BIT];
	assign display_frame_clock_sel_o = s.lcd[LCD_SRC_BIT];

endmodule // sbwcc_top

`default_nettype wire

//--- rtl/sbwcc_pkg.sv
// standby, watchdog and clock control: shared constants and types
// assumes a 40 MHz system clock and a classic wishbone master
//
// Rules for this block, its software and its reset source
// R1 - reset clears display frame clock source select
// R2 - sub oscillator stays stopped after reset
// R3 - software switches frame source after oscillator stable
// R4 - software disables display before stop instruction
// R5 - software writes only final display memory data
// R6 - watchdog keeps counting in wait mode
// R7 - software refreshes watchdog often during wait
// R8 - watchdog halts in stop, counts while stabilising
// R9 - software refreshes watchdog right before stop
// R10 - watchdog counts on selected system clock
// R11 - stop disable bit is sticky once set
// R12 - interrupt ends stop and restarts oscillators
// R13 - stop release clears timer mode except bit4
// R14 - main stabilisation delay when main was system
// R15 - reset pin in wait restarts main, stops sub
// R16 - reset source holds pin until stable plus 2us
// R17 - mode change only with stable target oscillator; not checked here, a cpu mode write switches the system clock at once
// R18 - watchdog underflow acts as reset pin

package sbwcc_pkg;

	// ------------------------------------------------
	// register indexes, byte address is index times four
	// ------------------------------------------------
	localparam logic [7:0] IDX_TMR_MODE = 8'h2c;
	localparam logic [7:0] IDX_WDOG_CTRL = 8'h37;
	localparam logic [7:0] IDX_LCD_MODE = 8'h39;
	localparam logic [7:0] IDX_CPU_MODE = 8'h3b;
	localparam logic [7:0] IDX_STBY_CMD = 8'h3e;
	localparam logic [7:0] IDX_STBY_STAT = 8'h3f;

	// ------------------------------------------------
	// field positions
	// ------------------------------------------------
	localparam int LCD_SRC_BIT = 7;
	localparam int LCD_EN_BIT = 3;
	localparam int WD_STPDIS_BIT = 6;
	localparam int CPU_SYSSEL_BIT = 7;
	localparam int CPU_MAINSTOP_BIT = 6;
	localparam int CPU_SUBEN_BIT = 4;
	localparam int CMD_STOP_BIT = 0;
	localparam int CMD_WAIT_BIT = 1;
	localparam logic [7:0] TMR_KEEP_MASK = 8'h10;

	// ------------------------------------------------
	// reset values
	// ------------------------------------------------
	localparam logic [7:0] LCD_MODE_RST = 8'h00;
	localparam logic [7:0] CPU_MODE_RST = 8'h00;
	localparam logic [7:0] TMR_MODE_RST = 8'h00;

	// ------------------------------------------------
	// timing counts, in oscillator edges
	// ------------------------------------------------
	localparam int WD_WIDTH = 16;
	localparam int STAB_WIDTH = 16;
	localparam logic [15:0] MAIN_STAB_TICKS = 16'h0800;
	localparam logic [15:0] SUB_STAB_TICKS = 16'h0100;

	typedef enum logic [1:0] {SB_RUN, SB_WAIT, SB_STOP, SB_STABLE} sbwcc_state_t;

endpackage

//--- rtl/sbwcc_if.sv
// signals between the control core, the watchdog and the oscillator monitor
// assumes all three sit on clk_i
`timescale 1ns/1ps
`default_nettype none

interface sbwcc_clk_if;
	logic main_tick;
	logic sub_tick;
	logic stab_go;
	logic stab_main;
	logic stab_done;
	logic wd_tick;
	logic wd_run;
	logic wd_load;
	logic wd_uflow;
	logic [7:0] wd_hi;

	modport ctl (output stab_go, stab_main, wd_tick, wd_run, wd_load,
		input main_tick, sub_tick, stab_done, wd_uflow, wd_hi);
	modport osc (input stab_go, stab_main, output main_tick, sub_tick, stab_done);
	modport wdg (input wd_tick, wd_run, wd_load, output wd_uflow, wd_hi);
endinterface

`default_nettype wire

//--- rtl/sbwcc_wdog.sv
// watchdog down counter with underflow pulse
// assumes wd_tick is a one-cycle pulse per system clock edge
`timescale 1ns/1ps
`default_nettype none

module sbwcc_wdog
	import sbwcc_pkg::*;
#(
	parameter int WIDTH = WD_WIDTH
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// control channel
	sbwcc_clk_if.wdg ch
);

	typedef struct packed {
		logic [WIDTH-1:0] cnt;
		logic uflow;
	} sbwcc_wd_t;

	sbwcc_wd_t s;
	sbwcc_wd_t next_s;

	// ------------------------------------------------
	// counting
	// ------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.uflow = 1'b0;
		if (ch.wd_load) begin
			next_s.cnt = '1;
		end else if (ch.wd_run && ch.wd_tick) begin // R6 R8 R10
			if (s.cnt == '0) begin
				next_s.uflow = 1'b1; // R18
				next_s.cnt = '1;
			end else begin
				next_s.cnt = s.cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s.cnt <= '1;
			s.uflow <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	assign ch.wd_uflow = s.uflow;
	assign ch.wd_hi = s.cnt[WIDTH-1 -: 8];

endmodule // sbwcc_wdog

`default_nettype wire

//--- rtl/sbwcc_osc.sv
// oscillator pin monitor and stabilisation timer
// assumes the oscillator pins run well below half of clk_i
`timescale 1ns/1ps
`default_nettype none

module sbwcc_osc
	import sbwcc_pkg::*;
#(
	parameter logic [STAB_WIDTH-1:0] MAIN_TICKS = MAIN_STAB_TICKS,
	parameter logic [STAB_WIDTH-1:0] SUB_TICKS = SUB_STAB_TICKS
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// oscillator pins
	input wire logic main_osc_input_i,
	input wire logic sub_osc_input_i,
	// control channel
	sbwcc_clk_if.osc ch
);

	typedef struct packed {
		logic [2:0] msh;
		logic [2:0] ssh;
		logic [STAB_WIDTH-1:0] cnt;
		logic use_main;
		logic busy;
		logic done;
	} sbwcc_osc_t;

	sbwcc_osc_t s;
	sbwcc_osc_t next_s;
	logic mtick;
	logic stick;

	// edges are taken after two flops, the third only remembers history
	assign mtick = s.msh[1] & ~s.msh[2];
	assign stick = s.ssh[1] & ~s.ssh[2];

	// ------------------------------------------------
	// stabilisation timer
	// ------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.msh = {s.msh[1:0], main_osc_input_i};
		next_s.ssh = {s.ssh[1:0], sub_osc_input_i};
		next_s.done = 1'b0;
		if (ch.stab_go) begin
			next_s.busy = 1'b1;
			next_s.use_main = ch.stab_main;
			next_s.cnt = ch.stab_main ? MAIN_TICKS : SUB_TICKS; // R14
		end else if (s.busy && (s.use_main ? mtick : stick)) begin
			if (s.cnt <= 1) begin
				next_s.busy = 1'b0;
				next_s.done = 1'b1;
			end else begin
				next_s.cnt = s.cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign ch.main_tick = mtick;
	assign ch.sub_tick = stick;
	assign ch.stab_done = s.done;

endmodule // sbwcc_osc

`default_nettype wire

//--- tb/sbwcc_asserts.sv
// port checks for the standby sequencer
// assumes a bind onto sbwcc_top, one clock
`timescale 1ns/1ps
`default_nettype none
module sbwcc_asserts
	import sbwcc_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	// core and clocks
	input wire logic irq_i,
	input wire logic cpu_halt_o,
	input wire logic internal_reset_o,
	input wire logic [7:0] timer_mode_o,
	input wire logic main_osc_en_o,
	input wire logic sub_osc_en_o,
	input wire logic display_frame_clock_sel_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// both enables low while halted happens in stop, or when the cpu mode stops main and leaves sub off
	sequence s_wake;
		cpu_halt_o && !main_osc_en_o && !sub_osc_en_o && irq_i;
	endsequence
	a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	a_ack_next_edge: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	a_reset_clock_sel: assert property ($fell(rst_i) |-> main_osc_en_o && !sub_osc_en_o && !display_frame_clock_sel_o)
		else $error("bad clocks after reset");
	a_wake_osc_on: assert property (s_wake |=> main_osc_en_o || sub_osc_en_o)
		else $error("oscillator not restarted");
	a_wake_timer_clear: assert property (s_wake |=> timer_mode_o == ($past(timer_mode_o) & TMR_KEEP_MASK))
		else $error("timer mode not cleared");
	a_stab_keeps_halt: assert property (cpu_halt_o && $rose(main_osc_en_o) |-> cpu_halt_o [*8])
		else $error("stabilisation too short");
	a_int_reset_clks: assert property (internal_reset_o |=> main_osc_en_o && !sub_osc_en_o && !cpu_halt_o)
		else $error("reset left clocks wrong");
	a_wait_cmd_halts: assert property (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == {IDX_STBY_CMD, 2'b00}
		&& wb_dat_i[1:0] == 2'b10 && !cpu_halt_o |=> cpu_halt_o)
		else $error("wait not entered");
	cover property (s_wake);
	cover property ($rose(internal_reset_o));
	cover property ($rose(cpu_halt_o));
endmodule // sbwcc_asserts
`default_nettype wire

//--- tb/sbwcc_osc_model.sv
// main and sub oscillators facing the block
// assumes the enables come from the block on clk_i
`timescale 1ns/1ps
`default_nettype none
module sbwcc_osc_model (
	// clock
	input wire logic clk_i,
	// enables
	input wire logic main_en_i,
	input wire logic sub_en_i,
	// pins
	output logic main_o,
	output logic sub_o
);
	logic [2:0] div = 3'h0;
	initial {main_o, sub_o} = 2'b00;
	// main four times the sub rate, above the 3x floor
	// a halted oscillator freezes; no startup jitter is modelled
	always @(posedge clk_i) begin
		div <= div + 3'h1;
		if (main_en_i && div[0])
			main_o <= ~main_o;
		if (sub_en_i && div == 3'h7)
			sub_o <= ~sub_o;
	end
endmodule // sbwcc_osc_model
`default_nettype wire

//--- tb/sbwcc_bench.sv
// self-checking bench for the standby sequencer
// assumes the oscillator model and the checker
`timescale 1ns/1ps
`default_nettype none
module sbwcc_bench
	import sbwcc_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, irq = 1'b0, rstn = 1'b1;
	logic [3:0] sel = 4'h1;
	logic [7:0] adr = 8'h00, d = 8'h00, a, tmr;
	logic [31:0] q, rd;
	logic ack, halt, irst, men, sen, ssub, den, fsel, mpin, spin;
	int fail_count = 0, comparisons = 0, cycles = 0, n;
	// short counts keep the watchdog run near 1000 cycles
	sbwcc_top #(.MAIN_TICKS(16'h0004), .SUB_TICKS(16'h0004), .WD_W(8)) u_sbwcc_top (.clk_i(clk_i),
		.rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i({adr, 2'b00}),
		.wb_sel_i(sel), .wb_dat_i({24'h000000, d}), .wb_dat_o(rd), .wb_ack_o(ack), .reset_n_i(rstn),
		.main_osc_input_i(mpin), .sub_osc_input_i(spin), .irq_i(irq), .cpu_halt_o(halt),
		.internal_reset_o(irst), .timer_mode_o(tmr), .main_osc_en_o(men), .sub_osc_en_o(sen),
		.sys_clk_sub_o(ssub), .display_enable_o(den), .display_frame_clock_sel_o(fsel));
	sbwcc_osc_model u_sbwcc_osc_model (.clk_i(clk_i), .main_en_i(men), .sub_en_i(sen),
		.main_o(mpin), .sub_o(spin));
	initial forever #12.5 clk_i = ~clk_i;
	task automatic report_and_stop;
		$display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic tk(input int c);
		repeat (c) @(posedge clk_i);
	endtask
	task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] v);
		int k = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= i;
		d <= v;
		while (ack !== 1'b1 && k < 20) begin
			@(posedge clk_i);
			k++;
		end
		q = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (k == 20)
			fail_count++;
	endtask
	task automatic pulse;
		@(posedge clk_i);
		irq <= 1'b1;
		@(posedge clk_i);
		irq <= 1'b0;
	endtask
	task automatic s_reset;
		chk(32'({fsel, sen}), 0);
		wb(0, IDX_LCD_MODE, 0);
		chk(q, 32'(LCD_MODE_RST));
		sel <= 4'h0;
		wb(1, IDX_LCD_MODE, 8'h88);
		sel <= 4'h1;
		wb(1, 8'h00, 8'hff);
		wb(0, 8'h00, 0);
		chk(q, 0);
		chk(32'(den), 0);
	endtask
	task automatic s_clock;
		wb(1, IDX_CPU_MODE, 8'h10);
		tk(40); // sub left to settle before it feeds the display
		chk(32'(sen), 1);
		wb(1, IDX_LCD_MODE, 8'h88); // one final value while lit, no interim writes
		tk(1);
		chk(32'({fsel, den}), 3);
	endtask
	task automatic s_wait;
		wb(1, IDX_WDOG_CTRL, 0);
		wb(1, IDX_STBY_CMD, 8'h02);
		tk(40);
		wb(0, IDX_STBY_STAT, 0);
		chk(32'(q[1:0]), 1);
		chk(32'(q[15:8] < 8'hf8), 1);
		pulse();
		tk(1);
		chk(32'(halt), 0);
	endtask
	task automatic s_stop;
		wb(1, IDX_TMR_MODE, 8'hff);
		wb(1, IDX_LCD_MODE, 8'h80);
		wb(1, IDX_WDOG_CTRL, 0);
		wb(1, IDX_STBY_CMD, 8'h01);
		wb(0, IDX_STBY_STAT, 0);
		a = q[15:8];
		chk(32'({halt, men, sen}), 4);
		tk(60);
		wb(0, IDX_STBY_STAT, 0);
		chk(32'(q[15:8]), 32'(a));
		pulse();
		tk(1);
		chk(32'({men, sen, tmr}), 32'h310);
		tk(6);
		chk(32'(halt), 1);
		n = 0;
		while (halt !== 1'b0 && n < 200) begin
			tk(1);
			n++;
		end
		chk(32'(halt), 0);
		wb(0, IDX_STBY_STAT, 0);
		chk(32'(q[15:8] < a), 1);
	endtask
	task automatic s_sticky;
		wb(1, IDX_WDOG_CTRL, 8'h40);
		wb(1, IDX_WDOG_CTRL, 8'h00);
		wb(0, IDX_WDOG_CTRL, 0);
		chk(q, 32'h40);
		wb(1, IDX_STBY_CMD, 8'h01);
		tk(2);
		chk(32'(halt), 0);
	endtask
	task automatic s_pin;
		wb(1, IDX_CPU_MODE, 8'hd0);
		wb(1, IDX_WDOG_CTRL, 0);
		tk(64);
		wb(0, IDX_STBY_STAT, 0);
		chk(32'(q[15:8] > 8'hf8), 1);
		chk(32'({men, sen, ssub}), 3);
		wb(1, IDX_STBY_CMD, 8'h02);
		@(posedge clk_i);
		rstn <= 1'b0;
		tk(6);
		chk(32'({men, sen, halt, irst}), 9);
		tk(80); // pin held past settling plus 2 us
		rstn <= 1'b1;
		tk(6);
		chk(32'({ssub, irst}), 0);
	endtask
	task automatic s_wdog;
		wb(1, IDX_LCD_MODE, 8'h80);
		tk(1);
		chk(32'(fsel), 1);
		n = 0;
		while (irst !== 1'b1 && n < 3000) begin
			tk(1);
			n++;
		end
		chk(32'(irst), 1);
		chk(32'(n > 900), 1);
		tk(2);
		chk(32'(fsel), 0);
	endtask
	initial begin
		tk(6);
		rst_i <= 1'b0;
		s_reset();
		s_clock();
		s_wait();
		s_stop();
		s_sticky();
		s_pin();
		s_wdog();
		report_and_stop();
	end
endmodule // sbwcc_bench
bind sbwcc_top sbwcc_asserts u_sbwcc_asserts (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_sel_i, .wb_dat_i, .wb_ack_o, .irq_i, .cpu_halt_o, .internal_reset_o, .timer_mode_o,
	.main_osc_en_o, .sub_osc_en_o, .display_frame_clock_sel_o);
`default_nettype wire
